/* File: core/ufie_pkg.sv */
package ufie_pkg;
   localparam logic [7:0] FALL_EN_ADDR = 8'h10;
   localparam logic [7:0] FALL_EN_SET_ADDR = 8'h11;
   localparam logic [7:0] FALL_EN_CLR_ADDR = 8'h12;
   localparam logic [7:0] SRC_LEVEL_ADDR = 8'h13;
   localparam logic [7:0] LATCH_ADDR = 8'h14;
   localparam int NUM_SRC = 5;
   localparam int BIT_ID_GROUND = 4;
   localparam int BIT_SESSION_END = 3;
   localparam int BIT_SESSION_VALID = 2;
   localparam int BIT_BUS_VOLTAGE_OK = 1;
   localparam int BIT_HOST_DISCONNECT = 0;
   localparam logic [4:0] FALL_EN_RESET = 5'h1f;
   localparam int ID_SETTLE_MS = 50;
   localparam int CLK_MHZ = 200;
   localparam int ID_SETTLE_CYCLES = ID_SETTLE_MS * 1000 * CLK_MHZ;
   localparam int SETTLE_W = 24;
endpackage : ufie_pkg

/* File: core/ufie_settle_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// holds busy while pull-up is off and for a settle time after it turns on
module ufie_settle_timer
   import ufie_pkg::*;
#(
   parameter int SETTLE_CYCLES = ID_SETTLE_CYCLES
)
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic pullup_on_i,
   output logic busy_o
);
   typedef struct packed {
      logic [SETTLE_W-1:0] count;
      logic busy;
   } ufie_timer_state_t;

   ufie_timer_state_t state_reg;
   ufie_timer_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      if (!pullup_on_i)
      begin
         state_next.count = SETTLE_W'(SETTLE_CYCLES);
         state_next.busy = 1'b1;
      end
      else if (state_reg.count != '0)
      begin
         state_next.count = state_reg.count - 1'b1;
         state_next.busy = (state_reg.count != SETTLE_W'(1));
      end
      else
      begin
         state_next.busy = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_reg.count <= '0;
         state_reg.busy <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign busy_o = state_reg.busy;
endmodule : ufie_settle_timer
`default_nettype wire

/* File: core/ufie_fall_enable.sv */
`timescale 1ns/100ps
`default_nettype none
module ufie_fall_enable
   import ufie_pkg::*;
#(
   parameter int SETTLE_CYCLES = ID_SETTLE_CYCLES
)
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic id_ground_i,
   input wire logic session_end_i,
   input wire logic a_device_session_ok_i,
   input wire logic bus_voltage_ok_i,
   input wire logic host_disconnect_i,
   input wire logic identity_pullup_on_i,
   input wire logic plus_line_pulldown_i,
   input wire logic minus_line_pulldown_i,
   input wire logic low_power_i,
   output logic [4:0] fall_event_o,
   output logic [4:0] fall_latch_o
);
   typedef struct packed {
      logic [4:0] enable;
      logic [4:0] level;
      logic [4:0] latch;
      logic [4:0] event_q;
      logic id_hold;
      logic [7:0] rdata;
   } ufie_state_t;

   ufie_state_t state_reg;
   ufie_state_t state_next;
   logic id_busy;
   logic [4:0] raw;
   logic [4:0] unmasked;
   logic [4:0] falls;
   logic host_mode;
   logic en_hit;

   // zero-extends a five-bit view to the byte read back
   function automatic logic [7:0] pad8(input logic [4:0] v);
      pad8 = {3'h0, v};
   endfunction : pad8

   // storage address and both of its aliases
   function automatic logic is_enable_addr(input logic [7:0] a);
      is_enable_addr = (a == FALL_EN_ADDR) || (a == FALL_EN_SET_ADDR)
                       || (a == FALL_EN_CLR_ADDR);
   endfunction : is_enable_addr

   // levels as the status register shows them
   function automatic logic [4:0] source_levels(
      input logic busy,
      input logic held_id,
      input logic id_now,
      input logic se_now,
      input logic sv_now,
      input logic bv_now,
      input logic hd_now,
      input logic low_pwr
   );
      logic [4:0] v;
      v = '0;
      v[BIT_ID_GROUND] = busy ? held_id : id_now;
      v[BIT_SESSION_END] = se_now;
      v[BIT_SESSION_VALID] = sv_now;
      v[BIT_BUS_VOLTAGE_OK] = bv_now;
      v[BIT_HOST_DISCONNECT] = low_pwr ? 1'b0 : hd_now;
      source_levels = v;
   endfunction : source_levels

   // sources whose falling edges may count in this cycle
   function automatic logic [4:0] source_mask(
      input logic busy,
      input logic hold,
      input logic host
   );
      logic [4:0] m;
      m = 5'h1f;
      m[BIT_ID_GROUND] = ~busy & ~hold;
      m[BIT_HOST_DISCONNECT] = host;
      source_mask = m;
   endfunction : source_mask

   // new enable value for a write through any of the three addresses
   function automatic logic [4:0] merge_enable(
      input logic [7:0] a,
      input logic [4:0] cur,
      input logic [4:0] wd
   );
      case (a)
         FALL_EN_ADDR:
         begin
            merge_enable = wd;
         end
         FALL_EN_SET_ADDR:
         begin
            merge_enable = cur | wd;
         end
         FALL_EN_CLR_ADDR:
         begin
            merge_enable = cur & ~wd;
         end
         default:
         begin
            merge_enable = cur;
         end
      endcase
   endfunction : merge_enable

   // byte returned for a read of the given address
   function automatic logic [7:0] read_select(
      input logic [7:0] a,
      input logic [4:0] en,
      input logic [4:0] lvl,
      input logic [4:0] lat
   );
      if (is_enable_addr(a))
      begin
         read_select = pad8(en);
      end
      else if (a == SRC_LEVEL_ADDR)
      begin
         read_select = pad8(lvl);
      end
      else if (a == LATCH_ADDR)
      begin
         read_select = pad8(lat);
      end
      else
      begin
         read_select = 8'h00;
      end
   endfunction : read_select

   ufie_settle_timer #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .pullup_on_i(identity_pullup_on_i),
      .busy_o(id_busy)
   );

   always_comb
   begin
      state_next = state_reg;
      host_mode = plus_line_pulldown_i & minus_line_pulldown_i;
      raw = source_levels(id_busy, state_reg.level[BIT_ID_GROUND],
                          id_ground_i, session_end_i, a_device_session_ok_i,
                          bus_voltage_ok_i, host_disconnect_i, low_power_i);
      // a change hidden by the settle window must not count when it ends
      unmasked = source_mask(id_busy, state_reg.id_hold, host_mode);
      falls = state_reg.level & ~raw & unmasked
              & state_reg.enable;
      state_next.level = raw;
      state_next.event_q = falls;
      state_next.id_hold = id_busy;
      en_hit = is_enable_addr(reg_addr_i);
      if (reg_wr_i && en_hit)
      begin
         state_next.enable = merge_enable(reg_addr_i, state_reg.enable,
                                          reg_wdata_i[4:0]);
      end
      state_next.rdata = 8'h00;
      if (reg_rd_i)
      begin
         state_next.rdata = read_select(reg_addr_i, state_reg.enable,
                                        state_reg.level,
                                        state_reg.latch | falls);
      end
      // read clears; an event in the read cycle shows in the read data
      if (reg_rd_i && (reg_addr_i == LATCH_ADDR))
      begin
         state_next.latch = '0;
      end
      else
      begin
         state_next.latch = state_reg.latch | falls;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_reg.enable <= FALL_EN_RESET;
         state_reg.level <= 5'h00;
         state_reg.latch <= 5'h00;
         state_reg.event_q <= 5'h00;
         state_reg.id_hold <= 1'b1;
         state_reg.rdata <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata_o = state_reg.rdata;
   assign fall_event_o = state_reg.event_q;
   assign fall_latch_o = state_reg.latch;
endmodule : ufie_fall_enable
`default_nettype wire

/* File: testbench/ufie_link_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ufie_link_model
(
   input wire logic ck_i,
   input wire logic [7:0] q_i,
   output logic [7:0] a_o = 8'h00,
   output logic [7:0] d_o = 8'h00,
   output logic w_o = 1'b0,
   output logic r_o = 1'b0
);
   // one register access, held until the strobe edge
   task automatic xfer(input logic w, input logic [7:0] a, v,
      output logic [7:0] q);
      @(posedge ck_i);
      a_o <= a;
      d_o <= v;
      w_o <= w;
      r_o <= !w;
      @(posedge ck_i);
      w_o <= 1'b0;
      r_o <= 1'b0;
      #1 q = q_i;
   endtask : xfer
endmodule : ufie_link_model
`default_nettype wire

/* File: testbench/ufie_fall_enable_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module ufie_fall_enable_chk
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic session_end_i,
   input wire logic identity_pullup_on_i,
   input wire logic [4:0] fall_event_o,
   input wire logic [4:0] fall_latch_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_idl; !reg_rd_i |=> !reg_rdata_o; endproperty
   a_idl: assert property (p_idl) else $error("idle");
   property p_rsv; reg_rd_i |=> !reg_rdata_o[7:5]; endproperty
   a_rsv: assert property (p_rsv) else $error("rsv");
   property p_sts; reg_rd_i && reg_addr_i == 8'h13 && $stable(session_end_i)
      && $past(rst_b_i) |=> reg_rdata_o[3] == $past(session_end_i);
   endproperty
   a_sts: assert property (p_sts) else $error("sts");
   property p_gap; fall_event_o[3] |=> !fall_event_o[3]; endproperty
   a_gap: assert property (p_gap) else $error("gap");
   property p_fal; fall_event_o[3] |-> $past(session_end_i, 2)
      && !$past(session_end_i); endproperty
   a_fal: assert property (p_fal) else $error("fall");
   property p_id; fall_event_o[4] |-> $past(identity_pullup_on_i, 16);
   endproperty
   a_id: assert property (p_id) else $error("id");
   property p_set; $rose(fall_latch_o[3]) |-> fall_event_o[3]; endproperty
   a_set: assert property (p_set) else $error("set");
   property p_clr; reg_rd_i && reg_addr_i == 8'h14 |=> !fall_latch_o;
   endproperty
   a_clr: assert property (p_clr) else $error("clr");
   cover property (fall_event_o[4]);
   cover property (fall_event_o[0]);
   cover property (fall_event_o[3]);
endmodule : ufie_fall_enable_chk
bind ufie_fall_enable ufie_fall_enable_chk chk_u (.*);
`default_nettype wire

/* File: testbench/ufie_fall_enable_test.sv */
`timescale 1ns/100ps
`default_nettype none
module ufie_fall_enable_test;
   logic ref_clk_i = 1'b0, rst_b_i = 1'b0, low_power_i = 1'b0, hm = 1'b0;
   logic identity_pullup_on_i = 1'b0, reg_wr_i, reg_rd_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
   logic [4:0] s = 5'h01, fall_event_o, fall_latch_o;
   wire logic id_ground_i = s[4], session_end_i = s[3];
   wire logic a_device_session_ok_i = s[2], bus_voltage_ok_i = s[1];
   wire logic host_disconnect_i = s[0], plus_line_pulldown_i = hm;
   wire logic minus_line_pulldown_i = hm;
   int n_errors = 0, tests_run = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   ufie_link_model link_u (.ck_i(ref_clk_i), .q_i(reg_rdata_o),
      .a_o(reg_addr_i), .d_o(reg_wdata_i), .w_o(reg_wr_i), .r_o(reg_rd_i));
   ufie_fall_enable #(.SETTLE_CYCLES(20)) dut_u (.*);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t %h %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a);
      link_u.xfer(1'b0, a, 8'h00, d);
   endtask : rd
   task automatic st(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : st
   task automatic t_regs;
      rd(8'h12);
      chk(d, 8'h1f);
      link_u.xfer(1'b1, 8'h12, 8'hfa, d);
      rd(8'h11);
      chk(d, 8'h05);
      link_u.xfer(1'b1, 8'h11, 8'he2, d);
      rd(8'h10);
      chk(d, 8'h07);
      link_u.xfer(1'b1, 8'h13, 8'hff, d);
      rd(8'h13);
      chk(d, 8'h01);
      rd(8'h16);
      chk(d, 8'h00);
   endtask : t_regs
   task automatic t_src;
      link_u.xfer(1'b1, 8'h10, 8'hfd, d);
      st(1);
      s <= 5'h1f;
      low_power_i <= 1'b1;
      st(3);
      rd(8'h13);
      chk(d, 8'h0e);
      st(1);
      s <= 5'h00;
      st(1);
      @(negedge ref_clk_i);
      chk({3'h0, fall_event_o}, 8'h0c);
      st(2);
      chk({3'h0, fall_latch_o}, 8'h0c);
      rd(8'h14);
      chk(d, 8'h0c);
      chk({3'h0, fall_latch_o}, 8'h00);
      st(1);
      {identity_pullup_on_i, hm, low_power_i} <= 3'h6;
      s <= 5'h11;
      st(30);
      rd(8'h13);
      chk(d, 8'h11);
      st(1);
      s <= 5'h00;
      st(1);
      @(negedge ref_clk_i);
      chk({3'h0, fall_event_o}, 8'h11);
      st(2);
      rd(8'h14);
      chk(d, 8'h11);
   endtask : t_src
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial
   begin
      st(20);
      rst_b_i <= 1'b1;
      t_regs;
      t_src;
      final_report;
   end
   initial
   begin
      st(2000);
      n_errors++;
      final_report;
   end
endmodule : ufie_fall_enable_test
`default_nettype wire
